// File: inc/pced_pkg.sv
/*
  Constants for the pin change edge detector: register byte offsets,
  field positions and the reset value.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package pced_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_PORTA_RISE = 6'h00;
  localparam logic [5:0] OFF_PORTA_FALL = 6'h04;
  localparam logic [5:0] OFF_PORTA_FLAGS = 6'h08;
  localparam logic [5:0] OFF_PORTB_RISE = 6'h0C;
  localparam logic [5:0] OFF_PORTB_FALL = 6'h10;
  localparam logic [5:0] OFF_PORTB_FLAGS = 6'h14;
  localparam logic [5:0] OFF_PORTC_RISE = 6'h18;
  localparam logic [5:0] OFF_PORTC_FALL = 6'h1C;
  localparam logic [5:0] OFF_PORTC_FLAGS = 6'h20;
  localparam logic [5:0] OFF_PORTE_RISE = 6'h24;
  localparam logic [5:0] OFF_PORTE_FALL = 6'h28;
  localparam logic [5:0] OFF_PORTE_FLAGS = 6'h2C;
  localparam logic [5:0] OFF_SUMMARY = 6'h30;
  localparam int unsigned PORTE_PIN = 3;
  localparam logic [7:0] PORTE_MASK = 8'h08;
  localparam logic [7:0] RESET_VAL = 8'h00;
endpackage

// File: hw/pced_top.sv
/*
  Pin change edge detector: three eight-bit ports and pin 3 of port E,
  with rising and falling enables and sticky flags behind an APB slave.
  Assumes pins are asynchronous to clk_sys; the interrupt unit consumes
  the summary flag and applies its own enable.
*/
// The implementer's own choices: the APB register port and the register offsets.
// Function
// - A set rising enable makes a low-to-high pin transition a qualifying event.
// - A set falling enable makes a high-to-low pin transition a qualifying event.
// - A rising edge with rising enable set sets the pin's flag.
// - A falling edge with falling enable set sets the flag; both enables catch both edges.
// - Any enabled edge also raises the shared summary flag.
// - With both enables clear no transition sets the flag.
// - A set flag stays 1 until software writes 0 to it.
// - Flags are software readable and writable and hardware settable on their own path.
// - All enables and flags reset to 0 on every reset.
// - Ports A, B and C each have eight enables of each kind and eight flags, bit n for pin n.
// - On port E only pin 3 detects edges, at bit 3 of each register.
// - Unimplemented port E bits ignore writes and read as 0.
// - Detection and flags work regardless of the global interrupt enable.
// - An edge during a clearing write leaves its flag set.
// - The summary flag is the OR of all per-pin flags.
module pced_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] porta_pin_n,
  input wire logic [7:0] portb_pin_n,
  input wire logic [7:0] portc_pin_n,
  input wire logic porte_pin3,
  output logic pin_change_summary_flag
);
  // Per-port state, index 0..3 for ports A, B, C and E
  logic [7:0] rise_en [4];
  logic [7:0] fall_en [4];
  logic [7:0] flags [4];
  logic [7:0] next_flags [4];
  logic [3:0] wr_rise;
  logic [3:0] wr_fall;
  logic [3:0] wr_flag;
  logic setup_phase;
  logic access_phase;
  logic rd_setup;
  logic wr_acc;
  logic [5:0] addr;
  logic addr_ok;
  logic [7:0] rd_byte;
  logic next_summary;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;

  // Bus phases and address check
  assign addr = paddr[5:0];
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign rd_setup = setup_phase && !pwrite;
  assign addr_ok = (paddr[31:6] == 26'h0) && (addr[1:0] == 2'h0) &&
    (addr <= pced_pkg::OFF_SUMMARY);
  // Writes commit only at the access edge and only with the low byte strobed
  assign wr_acc = access_phase && pready && pwrite && pstrb[0] && addr_ok;

  // One write strobe per register; the summary address takes no write
  always_comb begin
    wr_rise = 4'h0;
    wr_fall = 4'h0;
    wr_flag = 4'h0;
    if (wr_acc) begin
      case (addr)
        pced_pkg::OFF_PORTA_RISE: begin
          wr_rise[0] = 1'b1;
        end
        pced_pkg::OFF_PORTA_FALL: begin
          wr_fall[0] = 1'b1;
        end
        pced_pkg::OFF_PORTA_FLAGS: begin
          wr_flag[0] = 1'b1;
        end
        pced_pkg::OFF_PORTB_RISE: begin
          wr_rise[1] = 1'b1;
        end
        pced_pkg::OFF_PORTB_FALL: begin
          wr_fall[1] = 1'b1;
        end
        pced_pkg::OFF_PORTB_FLAGS: begin
          wr_flag[1] = 1'b1;
        end
        pced_pkg::OFF_PORTC_RISE: begin
          wr_rise[2] = 1'b1;
        end
        pced_pkg::OFF_PORTC_FALL: begin
          wr_fall[2] = 1'b1;
        end
        pced_pkg::OFF_PORTC_FLAGS: begin
          wr_flag[2] = 1'b1;
        end
        pced_pkg::OFF_PORTE_RISE: begin
          wr_rise[3] = 1'b1;
        end
        pced_pkg::OFF_PORTE_FALL: begin
          wr_fall[3] = 1'b1;
        end
        pced_pkg::OFF_PORTE_FLAGS: begin
          wr_flag[3] = 1'b1;
        end
        default: begin
          wr_rise = 4'h0;
        end
      endcase
    end
  end

  // Read data of the addressed register
  always_comb begin
    rd_byte = 8'h00;
    case (addr)
      pced_pkg::OFF_PORTA_RISE: begin
        rd_byte = rise_en[0];
      end
      pced_pkg::OFF_PORTA_FALL: begin
        rd_byte = fall_en[0];
      end
      pced_pkg::OFF_PORTA_FLAGS: begin
        rd_byte = flags[0];
      end
      pced_pkg::OFF_PORTB_RISE: begin
        rd_byte = rise_en[1];
      end
      pced_pkg::OFF_PORTB_FALL: begin
        rd_byte = fall_en[1];
      end
      pced_pkg::OFF_PORTB_FLAGS: begin
        rd_byte = flags[1];
      end
      pced_pkg::OFF_PORTC_RISE: begin
        rd_byte = rise_en[2];
      end
      pced_pkg::OFF_PORTC_FALL: begin
        rd_byte = fall_en[2];
      end
      pced_pkg::OFF_PORTC_FLAGS: begin
        rd_byte = flags[2];
      end
      pced_pkg::OFF_PORTE_RISE: begin
        rd_byte = rise_en[3];
      end
      pced_pkg::OFF_PORTE_FALL: begin
        rd_byte = fall_en[3];
      end
      pced_pkg::OFF_PORTE_FLAGS: begin
        rd_byte = flags[3];
      end
      pced_pkg::OFF_SUMMARY: begin
        rd_byte = {7'h00, pin_change_summary_flag};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Ports A, B and C use all eight pins, bit n for pin n
  pced_port_cell #(
    .WIDTH(8),
    .IMPL(8'hFF)
  ) u_porta (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_level(porta_pin_n),
    .wr_data(pwdata[7:0]),
    .wr_rise(wr_rise[0]),
    .wr_fall(wr_fall[0]),
    .wr_flag(wr_flag[0]),
    .rise_en(rise_en[0]),
    .fall_en(fall_en[0]),
    .flags(flags[0]),
    .next_flags(next_flags[0])
  );

  pced_port_cell #(
    .WIDTH(8),
    .IMPL(8'hFF)
  ) u_portb (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_level(portb_pin_n),
    .wr_data(pwdata[7:0]),
    .wr_rise(wr_rise[1]),
    .wr_fall(wr_fall[1]),
    .wr_flag(wr_flag[1]),
    .rise_en(rise_en[1]),
    .fall_en(fall_en[1]),
    .flags(flags[1]),
    .next_flags(next_flags[1])
  );

  pced_port_cell #(
    .WIDTH(8),
    .IMPL(8'hFF)
  ) u_portc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_level(portc_pin_n),
    .wr_data(pwdata[7:0]),
    .wr_rise(wr_rise[2]),
    .wr_fall(wr_fall[2]),
    .wr_flag(wr_flag[2]),
    .rise_en(rise_en[2]),
    .fall_en(fall_en[2]),
    .flags(flags[2]),
    .next_flags(next_flags[2])
  );

  // Port E: only bit 3 is built, the other bits stay 0
  pced_port_cell #(
    .WIDTH(8),
    .IMPL(pced_pkg::PORTE_MASK)
  ) u_porte (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_level({4'h0, porte_pin3, 3'h0}),
    .wr_data(pwdata[7:0]),
    .wr_rise(wr_rise[3]),
    .wr_fall(wr_fall[3]),
    .wr_flag(wr_flag[3]),
    .rise_en(rise_en[3]),
    .fall_en(fall_en[3]),
    .flags(flags[3]),
    .next_flags(next_flags[3])
  );

  // Summary tracks the flag state loaded at the same edge
  assign next_summary = |{next_flags[0], next_flags[1], next_flags[2],
    next_flags[3]};

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_change_summary_flag <= 1'b0;
    end else begin
      pin_change_summary_flag <= next_summary;
    end
  end

  // APB answer: zero wait states, error on an unmapped or misaligned address
  assign next_pready = setup_phase;
  assign next_pslverr = setup_phase && !addr_ok;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (rd_setup && addr_ok) begin
      next_prdata = {24'h000000, rd_byte};
    end
  end

  // Ready pulses in the access cycle of every transfer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= next_pready;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pslverr;
    end
  end

  // Read data stands only in the access cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end
endmodule

// Two-flop synchroniser; nothing else reads its first stage
module pced_sync2 #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_out <= {WIDTH{1'b0}};
    end else begin
      sync_out <= stage1;
    end
  end
endmodule

// Edge detection, enables and sticky flags for the pins of one port
module pced_port_cell #(
  parameter int unsigned WIDTH = 8,
  parameter logic [WIDTH-1:0] IMPL = {WIDTH{1'b1}}
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_level,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_rise,
  input wire logic wr_fall,
  input wire logic wr_flag,
  output logic [WIDTH-1:0] rise_en,
  output logic [WIDTH-1:0] fall_en,
  output logic [WIDTH-1:0] flags,
  output logic [WIDTH-1:0] next_flags
);
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] edge_hit;
  localparam logic [WIDTH-1:0] RST = WIDTH'(pced_pkg::RESET_VAL);

  // Pin levels cross into clk_sys before any logic reads them
  pced_sync2 #(
    .WIDTH(WIDTH)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(pin_level),
    .sync_out(sync2)
  );

  // Previous sample for edge comparison
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prev <= RST;
    end else begin
      prev <= sync2;
    end
  end

  // Edge qualification, independent of any interrupt enable
  assign edge_hit = ((rise_en & sync2 & ~prev) |
    (fall_en & ~sync2 & prev)) & IMPL;

  // Unbuilt bits never store a 1
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rise_en <= RST;
    end else if (wr_rise) begin
      rise_en <= wr_data & IMPL;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fall_en <= RST;
    end else if (wr_fall) begin
      fall_en <= wr_data & IMPL;
    end
  end

  // Hardware set is ORed over the written value so a coincident edge wins
  assign next_flags = (wr_flag ? (wr_data & IMPL) : flags) |
    edge_hit;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flags <= RST;
    end else begin
      flags <= next_flags;
    end
  end
endmodule

// File: tb/pced_sva.sv
/* Port checker for the pin change edge detector.
   Assumes the zero-wait APB answers of the top module. */
module pced_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pin_change_summary_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_rd; pready && !pwrite; endsequence
  wire logic ok = paddr <= 32'h30 && paddr[1:0] == 2'h0;
  a_answer_next: assert property (s_setup |=> pready) else $error("no answer");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_map: assert property (pready |-> pslverr == !ok) else $error("bad error");
  a_read_top: assert property (s_rd |-> prdata[31:8] == 24'h0) else $error("high");
  a_porte_bits: assert property (pready && !pwrite && paddr inside {32'h24, 32'h28, 32'h2C}
    |-> (prdata[7:0] & 8'hF7) == 8'h0) else $error("port E bits");
  a_sum_reset: assert property ($fell(sys_rst) |-> !pin_change_summary_flag) else $error("rst");
  a_sum_hold: assert property (pin_change_summary_flag && !(psel && pwrite)
    |=> pin_change_summary_flag) else $error("summary dropped");
  a_sum_read: assert property (pready && !pwrite && paddr == 32'h30
    |-> prdata[0] == $past(pin_change_summary_flag)) else $error("summary read");
endmodule
bind pced_top pced_sva u_sva (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .pin_change_summary_flag);

// File: tb/pced_pins.sv
/* Pin-side partner: external pin levels, applied one clock after a request.
   Assumes the bench names the wanted level of all 25 pins. */
module pced_pins (
  input wire logic clk_sys,
  input wire logic [24:0] want,
  output logic [24:0] pins = 25'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk_sys) begin
    pins <= want;
  end
endmodule

// File: tb/testbench.sv
/* Self-checking bench for the pin change edge detector.
   Assumes zero-wait APB answers and a pin model one clock behind. */
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, sum;
  logic [24:0] want = 25'h0, pins, v;
  logic [7:0] rise [4], fall [4], exp_q [$], e_rd;
  integer mismatches = 0, checks = 0, seed = 32'h78D2;
  always #2 clk_sys = ~clk_sys;
  pced_pins u_pins (.clk_sys(clk_sys), .want(want), .pins(pins));
  pced_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .porta_pin_n(pins[7:0]), .portb_pin_n(pins[15:8]),
    .portc_pin_n(pins[23:16]), .porte_pin3(pins[24]), .pin_change_summary_flag(sum));
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 8'h0);
  endtask
  function automatic logic [7:0] pb(logic [24:0] x, int p);
    return p < 3 ? x[p * 8 +: 8] : {4'h0, x[24], 3'h0};
  endfunction
  task automatic flags(input logic f);
    logic [7:0] e;
    logic s;
    s = 1'b0;
    for (int p = 0; p < 4; p++) begin
      e = pb(v, p) & (f ? fall[p] : rise[p]);
      s |= |e;
      rd(p * 12 + 8, e);
    end
    rd(32'h30, {7'h0, s});
    `CHK(sum, s)
    for (int p = 0; p < 4; p++) wr(p * 12 + 8, 8'h0);
    rd(32'h30, 8'h0);
    `CHK(sum, 1'b0)
  endtask
  always @(posedge clk_sys) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      e_rd = exp_q.pop_front();
      `CHK(prdata, {24'h0, e_rd})
    end
  end
  task automatic final_report();
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 14; i++) rd(i * 4, 8'h0);
    for (int p = 0; p < 4; p++) begin
      rise[p] = 8'($random(seed));
      fall[p] = 8'($random(seed));
      wr(p * 12, rise[p]);
      wr(p * 12 + 4, fall[p]);
      if (p == 3) begin
        rise[p] &= 8'h08;
        fall[p] &= 8'h08;
      end
      rd(p * 12, rise[p]);
      rd(p * 12 + 4, fall[p]);
    end
    repeat (3) begin
      v = 25'($random(seed));
      want <= v;
      repeat (8) @(posedge clk_sys);
      flags(1'b0);
      want <= 25'h0;
      repeat (8) @(posedge clk_sys);
      flags(1'b1);
    end
    wr(32'h8, 8'hA5);
    rd(32'h8, 8'hA5);
    pstrb <= 4'hE;
    wr(32'h8, 8'h0);
    rd(32'h8, 8'hA5);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(32'h8, 8'h0);
    rd(32'h30, 8'h0);
    final_report();
  end
  initial begin
    #40000;
    mismatches++;
    final_report();
  end
endmodule
